/* File: cbm_consts.svh */
// Functional notes
// - 256K RAM in four 64K banks; bank and 16K segment pick a block.
// - DMA reaches all 256K; its bank choice ignores the CPU map entirely.
// - map code written to write-only port 17h applies to later CPU cycles.
// - map bit 4 places the 16K common area: 0 at C000, 1 at 0000.
// - map bit 3 fills the common area with bank 0 RAM or the EPROM.
// - map bits 2..0 select one of five logical banks, codes 000 to 100.
// - common on top, bank n: segments 0-2 map to bank n segments 0-2.
// - common on top, bank 4: segments 0-2 map to segment 3 of banks 1-3.
// - common at bottom, bank n: segments 1-3 map to bank n segments 1-3.
// - common at bottom, bank 4: segments 1-3 map to seg 0 of banks 1-3.
// - write-only DMA control registers at 14h and 15h; reads return zero.
// - any write to port 1Fh arms the return-from-interrupt sync logic.
// - port 1Bh reads hardware status and writes disk clock-chip control.
// - fixed port groups for serial, parallel, timer, sync serial and disk.
// - boot code overlays address zero after reset until I/O to port 1Ah.
`ifndef CBM_CONSTS_SVH
`define CBM_CONSTS_SVH

// ==========================================================
// i/o port addresses
`define CBM_PORT_FIRST_EXT 8'h14
`define CBM_PORT_SECOND_EXT 8'h15
`define CBM_PORT_DISK_EXT 8'h16
`define CBM_PORT_MAP_SEL 8'h17
`define CBM_PORT_SECOND_STAT 8'h18
`define CBM_PORT_SCSI 8'h19
`define CBM_PORT_FIRST_STAT 8'h1a
`define CBM_PORT_HW_STAT 8'h1b
`define CBM_PORT_RETI 8'h1f

// port groups of four, matched on address bits 7..2; timer group b has three, with port 1fh left out
`define CBM_GRP_ASYNC 6'h00
`define CBM_GRP_PAR 6'h01
`define CBM_GRP_TIMER_A 6'h02
`define CBM_GRP_SYNC 6'h03
`define CBM_GRP_DISK 6'h04
`define CBM_GRP_TIMER_B 6'h07
`define CBM_TIMER_B_HOLE 2'h3

// ==========================================================
// map select register fields
`define CBM_MAP_W 5
`define CBM_MAP_COMMON_BIT 4
`define CBM_MAP_EPROM_BIT 3
`define CBM_MAP_BANK_MSB 2
`define CBM_MAP_RESET 5'h00
`define CBM_LOGICAL_BANK4 3'h4
`define CBM_SEG_BOTTOM 2'h0
`define CBM_SEG_TOP 2'h3

// ==========================================================
// dma external control fields
`define CBM_EXT_RESET 8'h00
`define CBM_EXT_DEV_LSB 0
`define CBM_EXT_SRC_LSB 4
`define CBM_EXT_DST_LSB 6

// ==========================================================
// boot overlay
`define CBM_BOOT_SEG 2'h0

`endif

/* File: cbm_host_model.sv */
module cbm_host_model (
    // clock and what the cpu sees back
    input wire logic ref_clk,
    input wire logic epromSel,
    input wire logic bootRomSel,
    input wire logic [7:0] cpuReadData,
    input wire cbm_pkg::cbm_target_type cpuTarget,
    input wire logic [7:0] dmaReadData,
    input wire logic [17:0] dmaRamAddr,
    // cpu cycles
    output logic [15:0] cpuAddr,
    output logic cpuMemRead,
    output logic cpuMemWrite,
    output logic [7:0] cpuWriteData,
    output logic [7:0] extReadData,
    output logic [7:0] ioAddr,
    output logic ioRead,
    output logic ioWrite,
    // dma path
    output logic dmaReq,
    output logic dmaEngine,
    output logic dmaToDest,
    output logic dmaWrite,
    output logic [15:0] dmaAddr,
    output logic [7:0] dmaWriteData
);
    timeunit 1ns;
    timeprecision 100ps;
    import cbm_pkg::*;

    // ==========================================================
    // rom side: a pattern while selected, a toggling bus otherwise
    logic [7:0] idleBus;
    initial idleBus = 8'h0f;
    always @(posedge ref_clk) idleBus <= ~idleBus;
    assign extReadData = (epromSel || bootRomSel) ? cpuAddr[7:0] ^ 8'ha5
                                                   : idleBus;

    initial
    begin
        {cpuAddr, cpuMemRead, cpuMemWrite, cpuWriteData} = '0;
        {ioAddr, ioRead, ioWrite} = '0;
        {dmaReq, dmaEngine, dmaToDest, dmaWrite, dmaAddr, dmaWriteData} = '0;
    end

    // ==========================================================
    // bus cycles: driven after a falling edge, taken at the rising edge
    task automatic io_cycle(input logic wr, input logic [7:0] port,
                            input logic [7:0] data);
        @(negedge ref_clk);
        ioAddr = port;
        cpuWriteData = data;
        ioWrite = wr;
        ioRead = ~wr;
        @(posedge ref_clk);
        @(negedge ref_clk);
        ioWrite = 1'b0;
        ioRead = 1'b0;
        cpuWriteData = ~data;
    endtask

    task automatic mem_cycle(input logic wr, input logic [15:0] addr,
        input logic [7:0] data, output logic [7:0] rd, output logic [2:0] tg);
        @(negedge ref_clk);
        cpuAddr = addr;
        cpuWriteData = data;
        cpuMemWrite = wr;
        cpuMemRead = ~wr;
        @(posedge ref_clk);
        @(negedge ref_clk);
        rd = cpuReadData;
        tg = cpuTarget;
        cpuMemWrite = 1'b0;
        cpuMemRead = 1'b0;
    endtask

    task automatic dma_cycle(input logic wr, input logic eng,
        input logic dest, input logic [15:0] addr, input logic [7:0] data,
        output logic [7:0] rd, output logic [17:0] ra);
        @(negedge ref_clk);
        dmaReq = 1'b1;
        dmaWrite = wr;
        dmaEngine = eng;
        dmaToDest = dest;
        dmaAddr = addr;
        dmaWriteData = data;
        @(posedge ref_clk);
        @(negedge ref_clk);
        rd = dmaReadData;
        ra = dmaRamAddr;
        dmaReq = 1'b0;
        dmaWrite = 1'b0;
    endtask

    task automatic put_port(input logic [7:0] port);
        @(negedge ref_clk);
        ioAddr = port;
        @(posedge ref_clk);
    endtask
endmodule

/* File: cbm_mapper.sv */
`include "cbm_consts.svh"
module cbm_mapper (
    // clock and reset
    input wire logic ref_clk,
    input wire logic rst,
    // cpu memory cycle
    input wire logic [15:0] cpuAddr,
    input wire logic cpuMemRead,
    input wire logic cpuMemWrite,
    input wire logic [7:0] cpuWriteData,
    input wire logic [7:0] extReadData,
    output logic [7:0] cpuReadData,
    output cbm_pkg::cbm_target_type cpuTarget,
    output logic epromSel,
    output logic bootRomSel,
    output logic [13:0] epromAddr,
    // cpu i/o cycle
    input wire logic [7:0] ioAddr,
    input wire logic ioRead,
    input wire logic ioWrite,
    output logic [7:0] ioReadData,
    // straps and status
    input wire logic bootFromEprom,
    input wire logic [7:0] hwStatus,
    // peripheral selects
    output logic asyncSerialSel,
    output logic parallelSel,
    output logic timerGroupASel,
    output logic timerGroupBSel,
    output logic syncSerialSel,
    output logic diskCtrlSel,
    output logic diskExtSel,
    output logic scsiSel,
    output logic firstEngineSel,
    output logic secondEngineSel,
    // control outputs
    output logic [7:0] diskClockCtrl,
    output logic retiSyncArm,
    output logic [2:0] firstEngineDevice,
    output logic [2:0] secondEngineDevice,
    // dma path
    input wire logic dmaReq,
    input wire logic dmaEngine,
    input wire logic dmaToDest,
    input wire logic dmaWrite,
    input wire logic [15:0] dmaAddr,
    input wire logic [7:0] dmaWriteData,
    output logic [7:0] dmaReadData,
    output logic [17:0] dmaRamAddr
);
    import cbm_pkg::*;

    // ==========================================================
    // registers
    logic [4:0] map_reg;
    logic [7:0] firstExt_reg;
    logic [7:0] secondExt_reg;
    logic bootActive_reg;
    logic bootEprom_reg;
    logic [7:0] extData_reg;
    logic readRam_reg;
    logic [7:0] ramReadData;
    logic [1:0] physBank;
    logic [1:0] physSeg;
    logic useEprom;
    logic [17:0] cpuRamAddr;
    logic [17:0] ramAddr;
    logic ramWriteEn;
    logic [7:0] ramWriteData;
    logic [7:0] dmaExt;
    logic [1:0] dmaBank;
    logic mapWrite;
    logic overlayHit;

    assign mapWrite = ioWrite && (ioAddr == `CBM_PORT_MAP_SEL);

    // latch the map code for all later cpu accesses
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            map_reg <= `CBM_MAP_RESET;
        end
        else if (mapWrite)
        begin
            map_reg <= cpuWriteData[`CBM_MAP_W-1:0];
        end
    end

    // write-only dma external control registers
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            firstExt_reg <= `CBM_EXT_RESET;
            secondExt_reg <= `CBM_EXT_RESET;
        end
        else if (ioWrite && ioAddr == `CBM_PORT_FIRST_EXT)
        begin
            firstExt_reg <= cpuWriteData;
        end
        else if (ioWrite && ioAddr == `CBM_PORT_SECOND_EXT)
        begin
            secondExt_reg <= cpuWriteData;
        end
    end

    // boot overlay until any access to the first engine port
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            bootActive_reg <= 1'b1;
            bootEprom_reg <= bootFromEprom;
        end
        else if ((ioRead || ioWrite) && ioAddr == `CBM_PORT_FIRST_STAT)
        begin
            bootActive_reg <= 1'b0;
        end
    end

    // status read and clock-chip control write share one port
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            diskClockCtrl <= 8'h00;
            ioReadData <= 8'h00;
        end
        else
        begin
            if (ioWrite && ioAddr == `CBM_PORT_HW_STAT)
            begin
                diskClockCtrl <= cpuWriteData;
            end
            // write-only ports return zero
            ioReadData <= (ioRead && ioAddr == `CBM_PORT_HW_STAT) ?
                          hwStatus : 8'h00;
        end
    end

    // one-cycle arm pulse on any write to the last port
    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            retiSyncArm <= 1'b0;
        end
        else
        begin
            retiSyncArm <= ioWrite && (ioAddr == `CBM_PORT_RETI);
        end
    end

    // ==========================================================
    // i/o decode
    assign asyncSerialSel = ioAddr[7:2] == `CBM_GRP_ASYNC;
    assign parallelSel = ioAddr[7:2] == `CBM_GRP_PAR;
    assign timerGroupASel = ioAddr[7:2] == `CBM_GRP_TIMER_A;
    assign syncSerialSel = ioAddr[7:2] == `CBM_GRP_SYNC;
    assign diskCtrlSel = ioAddr[7:2] == `CBM_GRP_DISK;
    assign timerGroupBSel = (ioAddr[7:2] == `CBM_GRP_TIMER_B) &&
                            (ioAddr[1:0] != `CBM_TIMER_B_HOLE);
    assign diskExtSel = ioAddr == `CBM_PORT_DISK_EXT;
    assign scsiSel = ioAddr == `CBM_PORT_SCSI;
    assign firstEngineSel = ioAddr == `CBM_PORT_FIRST_STAT;
    assign secondEngineSel = ioAddr == `CBM_PORT_SECOND_STAT;
    assign firstEngineDevice = firstExt_reg[`CBM_EXT_DEV_LSB+:3];
    assign secondEngineDevice = secondExt_reg[`CBM_EXT_DEV_LSB+:3];

    // ==========================================================
    // cpu map translation
    cbm_seg_xlate i_cbm_seg_xlate (
        .mapCode(map_reg),
        .cpuSeg(cpuAddr[15:14]),
        .physBank(physBank),
        .physSeg(physSeg),
        .useEprom(useEprom)
    );

    assign cpuRamAddr = {physBank, physSeg, cpuAddr[13:0]};
    assign overlayHit = bootActive_reg && cpuAddr[15:14] == `CBM_BOOT_SEG;
    assign epromAddr = cpuAddr[13:0];

    // overlay serves reads only; overlay writes land in RAM
    always_comb
    begin
        if (overlayHit && cpuMemRead)
        begin
            cpuTarget = bootEprom_reg ? TGT_EPROM : TGT_BOOT;
        end
        else if (useEprom)
        begin
            cpuTarget = TGT_EPROM;
        end
        else
        begin
            cpuTarget = TGT_RAM;
        end
    end

    assign epromSel = cpuMemRead && cpuTarget == TGT_EPROM;
    assign bootRomSel = cpuMemRead && cpuTarget == TGT_BOOT;

    // ==========================================================
    // dma bank: own control register, never the cpu map
    assign dmaExt = dmaEngine ? secondExt_reg : firstExt_reg;
    assign dmaBank = dmaToDest ? dmaExt[`CBM_EXT_DST_LSB+:2]
                               : dmaExt[`CBM_EXT_SRC_LSB+:2];
    assign dmaRamAddr = {dmaBank, dmaAddr};

    // dma owns the RAM while it requests; eprom writes are dropped
    assign ramAddr = dmaReq ? dmaRamAddr : cpuRamAddr;
    assign ramWriteEn = dmaReq ? dmaWrite :
                        (cpuMemWrite && !useEprom);
    assign ramWriteData = dmaReq ? dmaWriteData : cpuWriteData;

    cbm_ram #(
        .ADDR_W(18),
        .DATA_W(8)
    ) i_cbm_ram (
        .ref_clk(ref_clk),
        .writeEn(ramWriteEn),
        .addr(ramAddr),
        .writeData(ramWriteData),
        .readData(ramReadData)
    );

    always_ff @(posedge ref_clk)
    begin
        if (rst)
        begin
            readRam_reg <= 1'b1;
            extData_reg <= 8'h00;
        end
        else if (cpuMemRead)
        begin
            readRam_reg <= cpuTarget == TGT_RAM;
            extData_reg <= extReadData;
        end
    end

    assign cpuReadData = readRam_reg ? ramReadData : extData_reg;
    assign dmaReadData = ramReadData;

    // ==========================================================
    // assertions
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (rst);

    property p_mapLatch;
        mapWrite |=> map_reg == $past(cpuWriteData[4:0]);
    endproperty
    a_mapLatch: assert property (p_mapLatch)
        else $error("map code not latched");

    property p_topCommonRam;
        (!map_reg[4] && !map_reg[3] && cpuAddr[15:14] == 2'h3)
            |-> cpuRamAddr[17:14] == 4'h3 && cpuTarget != TGT_EPROM;
    endproperty
    a_topCommonRam: assert property (p_topCommonRam)
        else $error("top common area not bank 0 segment 3");

    property p_epromCommon;
        (map_reg[3] && cpuMemRead && !overlayHit &&
         cpuAddr[15:14] == (map_reg[4] ? 2'h0 : 2'h3)) |-> epromSel;
    endproperty
    a_epromCommon: assert property (p_epromCommon)
        else $error("eprom not selected in common area");

    property p_topBankN;
        (!map_reg[4] && map_reg[2:0] < 3'h4 && cpuAddr[15:14] != 2'h3)
            |-> cpuRamAddr[17:14] == {map_reg[1:0], cpuAddr[15:14]};
    endproperty
    a_topBankN: assert property (p_topBankN)
        else $error("top common bank n mapping wrong");

    property p_topBank4;
        (!map_reg[4] && map_reg[2:0] == 3'h4 && cpuAddr[15:14] != 2'h3)
            |-> cpuRamAddr[17:14] == {cpuAddr[15:14] + 2'h1, 2'h3};
    endproperty
    a_topBank4: assert property (p_topBank4)
        else $error("logical bank 4 top mapping wrong");

    property p_botBankN;
        (map_reg[4] && map_reg[2:0] < 3'h4 && cpuAddr[15:14] != 2'h0)
            |-> cpuRamAddr[17:14] == {map_reg[1:0], cpuAddr[15:14]};
    endproperty
    a_botBankN: assert property (p_botBankN)
        else $error("bottom common bank n mapping wrong");

    property p_botBank4;
        (map_reg[4] && map_reg[2:0] == 3'h4 && cpuAddr[15:14] != 2'h0)
            |-> cpuRamAddr[17:14] == {cpuAddr[15:14], 2'h0};
    endproperty
    a_botBank4: assert property (p_botBank4)
        else $error("logical bank 4 bottom mapping wrong");

    sequence s_dmaSteady;
        $stable(dmaAddr) && $stable(dmaEngine) && $stable(dmaToDest) &&
        $stable(firstExt_reg) && $stable(secondExt_reg);
    endsequence
    property p_dmaIndep;
        (dmaReq && mapWrite) ##1 s_dmaSteady
            |-> $stable(dmaRamAddr);
    endproperty
    a_dmaIndep: assert property (p_dmaIndep)
        else $error("cpu map write moved dma address");

    sequence s_bootKill;
        (ioRead || ioWrite) && ioAddr == 8'h1a;
    endsequence
    property p_bootKill;
        s_bootKill |=> !bootActive_reg ##1 !bootActive_reg;
    endproperty
    a_bootKill: assert property (p_bootKill)
        else $error("boot overlay survived port 1a access");

    property p_retiPulse;
        (ioWrite && ioAddr == 8'h1f) ##1 !(ioWrite && ioAddr == 8'h1f)
            |-> retiSyncArm ##1 !retiSyncArm;
    endproperty
    a_retiPulse: assert property (p_retiPulse)
        else $error("reti arm pulse wrong");

    property p_statusRead;
        (ioRead && ioAddr == 8'h1b) |=> ioReadData == $past(hwStatus);
    endproperty
    a_statusRead: assert property (p_statusRead)
        else $error("status read wrong");

    property p_extNoRead;
        (ioRead && (ioAddr == 8'h14 || ioAddr == 8'h15))
            |=> ioReadData == 8'h00;
    endproperty
    a_extNoRead: assert property (p_extNoRead)
        else $error("write-only port returned data");

    property p_timerDecode;
        (ioAddr >= 8'h1c && ioAddr <= 8'h1e) |-> timerGroupBSel &&
            !timerGroupASel;
    endproperty
    a_timerDecode: assert property (p_timerDecode)
        else $error("timer group b decode wrong");

    property p_resetMap;
        disable iff (1'b0) rst |=> map_reg == 5'h00 && bootActive_reg;
    endproperty
    a_resetMap: assert property (p_resetMap)
        else $error("reset map state wrong");
endmodule

/* File: cbm_mapper_tb.sv */
`include "cbm_consts.svh"
module cbm_mapper_tb;
    timeunit 1ns;
    timeprecision 100ps;
    import cbm_pkg::*;

    logic ref_clk, rst, bootStrap, cpuMemRead, cpuMemWrite, ioRead, ioWrite;
    logic dmaReq, dmaEngine, dmaToDest, dmaWrite, epromSel, bootRomSel;
    logic [15:0] cpuAddr, dmaAddr;
    logic [7:0] cpuWriteData, extReadData, cpuReadData, ioAddr, ioReadData;
    logic [7:0] hwStat, diskClockCtrl, dmaWriteData, dmaReadData;
    logic [17:0] dmaRamAddr;
    logic [2:0] dev0, dev1;
    logic [9:0] sel;
    logic [13:0] epromAddr;
    logic [7:0] woPort [5] = '{8'h14, 8'h15, 8'h16, 8'h17, 8'h1f};
    logic retiSyncArm;
    cbm_target_type cpuTarget;
    int errCount, checks;

    cbm_mapper i_cbm_mapper (.ref_clk(ref_clk), .rst(rst), .cpuAddr(cpuAddr),
        .cpuMemRead(cpuMemRead), .cpuMemWrite(cpuMemWrite),
        .cpuWriteData(cpuWriteData), .extReadData(extReadData),
        .cpuReadData(cpuReadData), .cpuTarget(cpuTarget),
        .epromSel(epromSel), .bootRomSel(bootRomSel), .epromAddr(epromAddr),
        .ioAddr(ioAddr), .ioRead(ioRead), .ioWrite(ioWrite),
        .ioReadData(ioReadData), .bootFromEprom(bootStrap),
        .hwStatus(hwStat), .asyncSerialSel(sel[5]), .parallelSel(sel[4]),
        .timerGroupASel(sel[3]), .syncSerialSel(sel[2]),
        .diskCtrlSel(sel[1]), .timerGroupBSel(sel[0]), .diskExtSel(sel[9]),
        .scsiSel(sel[8]), .firstEngineSel(sel[7]), .secondEngineSel(sel[6]),
        .diskClockCtrl(diskClockCtrl), .retiSyncArm(retiSyncArm),
        .firstEngineDevice(dev0), .secondEngineDevice(dev1),
        .dmaReq(dmaReq), .dmaEngine(dmaEngine), .dmaToDest(dmaToDest),
        .dmaWrite(dmaWrite), .dmaAddr(dmaAddr), .dmaWriteData(dmaWriteData),
        .dmaReadData(dmaReadData), .dmaRamAddr(dmaRamAddr));

    cbm_host_model i_cbm_host_model (.ref_clk(ref_clk), .epromSel(epromSel),
        .bootRomSel(bootRomSel), .cpuReadData(cpuReadData),
        .cpuTarget(cpuTarget), .dmaReadData(dmaReadData),
        .dmaRamAddr(dmaRamAddr), .cpuAddr(cpuAddr), .cpuMemRead(cpuMemRead),
        .cpuMemWrite(cpuMemWrite), .cpuWriteData(cpuWriteData),
        .extReadData(extReadData), .ioAddr(ioAddr), .ioRead(ioRead),
        .ioWrite(ioWrite), .dmaReq(dmaReq), .dmaEngine(dmaEngine),
        .dmaToDest(dmaToDest), .dmaWrite(dmaWrite), .dmaAddr(dmaAddr),
        .dmaWriteData(dmaWriteData));

    // ==========================================================
    // clock, checking and closing
    initial
    begin
        ref_clk = 1'b0;
        forever #12.5 ref_clk = ~ref_clk;
    end

    task automatic check(input string name, input logic [17:0] seen,
                         input logic [17:0] exp);
        checks++;
        if (seen !== exp)
        begin
            errCount++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("errors %0d checks %0d", errCount, checks);
        if (errCount == 0 && checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // expected {eprom, bank, seg} of a cpu segment under a map code
    function automatic logic [4:0] exp_block(input logic [4:0] code,
                                             input logic [1:0] seg);
        logic bot;
        bot = code[4];
        if (seg == (bot ? 2'h0 : 2'h3))
            return {code[3], 2'h0, seg};
        if (code[2])
            return {1'b0, bot ? seg : seg + 2'h1, bot ? 2'h0 : 2'h3};
        return {1'b0, code[1:0], seg};
    endfunction

    initial
    begin
        #(25ns * 4000);
        errCount++;
        end_sim();
    end

    // ==========================================================
    // tests
    initial
    begin
        logic [7:0] rd;
        logic [2:0] tg;
        logic [4:0] blk;
        logic [17:0] ra;
        errCount = 0;
        checks = 0;
        rst = 1'b1;
        bootStrap = 1'b0;
        hwStat = 8'h3c;
        repeat (10) @(negedge ref_clk);
        rst = 1'b0;
        i_cbm_host_model.mem_cycle(1'b0, 16'h0123, 8'h00, rd, tg);
        check("boot target", tg, TGT_BOOT);
        check("boot data", rd, 8'h86);
        check("eprom addr", epromAddr, 14'h0123);
        // fill one byte of every 16k block through the dma path
        for (int b = 0; b < 4; b++)
        begin
            i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_FIRST_EXT,
                {b[1:0], 6'h05});
            check("engine device", dev0, 3'h5);
            for (int s = 0; s < 4; s++)
            begin
                i_cbm_host_model.dma_cycle(1'b1, 1'b0, 1'b1, {s[1:0], 14'h0123},
                    {4'h6, b[1:0], s[1:0]}, rd, ra);
                check("dma addr", ra, {b[1:0], s[1:0], 14'h0123});
            end
        end
        i_cbm_host_model.mem_cycle(1'b0, 16'h4123, 8'h00, rd, tg);
        check("reset map", rd, 8'h61);
        i_cbm_host_model.io_cycle(1'b0, 8'h1a, 8'h00);
        i_cbm_host_model.mem_cycle(1'b0, 16'h0123, 8'h00, rd, tg);
        check("overlay off", rd, 8'h60);
        // every defined map code, every cpu segment
        for (int c = 0; c < 32; c++)
        begin
            if (c[2:0] > 3'h4)
                continue;
            i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_MAP_SEL, c[7:0]);
            for (int s = 0; s < 4; s++)
            begin
                blk = exp_block(c[4:0], s[1:0]);
                i_cbm_host_model.mem_cycle(1'b0, {s[1:0], 14'h0123}, 8'h00, rd, tg);
                check("map target", tg, blk[4] ? TGT_EPROM : TGT_RAM);
                check("map data", rd, blk[4] ? 8'h86 : {4'h6, blk[3:0]});
            end
        end
        // dma source bank stays put while the cpu map moves
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_SECOND_EXT, 8'h23);
        for (int m = 0; m < 2; m++)
        begin
            fork
                i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_MAP_SEL,
                    m[0] ? 8'h13 : 8'h04);
                i_cbm_host_model.dma_cycle(1'b0, 1'b1, 1'b0, 16'h4123, 8'h00,
                    rd, ra);
            join
            check("dma read", rd, 8'h69);
            check("dma bank", ra, 18'h24123);
        end
        check("engine device", dev1, 3'h3);
        // eprom in common area takes no writes
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_MAP_SEL, 8'h08);
        i_cbm_host_model.mem_cycle(1'b1, 16'hc123, 8'hee, rd, tg);
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_MAP_SEL, 8'h00);
        i_cbm_host_model.mem_cycle(1'b0, 16'hc123, 8'h00, rd, tg);
        check("eprom write", rd, 8'h63);
        // write-only ports, status, disk clock control, sync arm
        foreach (woPort[i])
        begin
            i_cbm_host_model.io_cycle(1'b0, 8'h1b, 8'h00);
            i_cbm_host_model.io_cycle(1'b0, woPort[i], 8'h00);
            check("wo read", ioReadData, 8'h00);
        end
        i_cbm_host_model.io_cycle(1'b0, `CBM_PORT_HW_STAT, 8'h00);
        check("status", ioReadData, 8'h3c);
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_HW_STAT, 8'h9a);
        check("clock ctrl", diskClockCtrl, 8'h9a);
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_RETI, 8'h00);
        check("sync arm", retiSyncArm, 1'b1);
        @(negedge ref_clk);
        check("sync arm end", retiSyncArm, 1'b0);
        for (int p = 0; p < 32; p++)
        begin
            i_cbm_host_model.put_port(p[7:0]);
            check("decode", sel, {p == 22, p == 25, p == 26, p == 24, p < 4,
                p > 3 && p < 8, p > 7 && p < 12, p > 11 && p < 16,
                p > 15 && p < 20, p > 27 && p < 31});
        end
        // reset in mid-run with the eprom strap set
        i_cbm_host_model.io_cycle(1'b1, `CBM_PORT_MAP_SEL, 8'h03);
        bootStrap = 1'b1;
        rst = 1'b1;
        repeat (2) @(negedge ref_clk);
        rst = 1'b0;
        i_cbm_host_model.mem_cycle(1'b0, 16'h8123, 8'h00, rd, tg);
        check("rereset map", rd, 8'h62);
        i_cbm_host_model.mem_cycle(1'b0, 16'h0123, 8'h00, rd, tg);
        check("strap boot", tg, TGT_EPROM);
        end_sim();
    end
endmodule

/* File: cbm_pkg.sv */
package cbm_pkg;
    // ==========================================================
    // target of a cpu memory read
    typedef enum logic [2:0]
    {
        TGT_RAM = 3'b001,
        TGT_EPROM = 3'b010,
        TGT_BOOT = 3'b100
    } cbm_target_type;
endpackage

/* File: cbm_ram.sv */
module cbm_ram #(
    parameter int ADDR_W = 18,
    parameter int DATA_W = 8
) (
    // clock
    input wire logic ref_clk,
    // access
    input wire logic writeEn,
    input wire logic [ADDR_W-1:0] addr,
    input wire logic [DATA_W-1:0] writeData,
    output logic [DATA_W-1:0] readData
);
    import cbm_pkg::*;

    logic [DATA_W-1:0] mem [0:(1<<ADDR_W)-1];

    // four 64K banks addressed as {bank, segment, offset}
    always_ff @(posedge ref_clk)
    begin
        if (writeEn)
        begin
            mem[addr] <= writeData;
        end
        readData <= mem[addr];
    end
endmodule

/* File: cbm_seg_xlate.sv */
`include "cbm_consts.svh"
module cbm_seg_xlate (
    // map code and logical segment
    input wire logic [4:0] mapCode,
    input wire logic [1:0] cpuSeg,
    // physical result
    output logic [1:0] physBank,
    output logic [1:0] physSeg,
    output logic useEprom
);
    import cbm_pkg::*;

    logic commonHit;
    logic atBottom;
    logic [2:0] bankCode;

    assign atBottom = mapCode[`CBM_MAP_COMMON_BIT];
    assign bankCode = mapCode[`CBM_MAP_BANK_MSB:0];
    // common area at the top or bottom 16K
    assign commonHit = atBottom ? (cpuSeg == `CBM_SEG_BOTTOM)
                                : (cpuSeg == `CBM_SEG_TOP);

    always_comb
    begin
        physBank = 2'h0;
        physSeg = cpuSeg;
        useEprom = 1'b0;
        if (commonHit)
        begin
            // bank 0 RAM or the EPROM fills the common area
            useEprom = mapCode[`CBM_MAP_EPROM_BIT];
        end
        else if (bankCode == `CBM_LOGICAL_BANK4)
        begin
            // logical bank 4 from spare segments
            if (atBottom)
            begin
                physBank = cpuSeg;
                physSeg = `CBM_SEG_BOTTOM;
            end
            else
            begin
                physBank = cpuSeg + 2'h1;
                physSeg = `CBM_SEG_TOP;
            end
        end
        else
        begin
            // banks 0 to 3 keep the segment number
            physBank = bankCode[1:0];
        end
    end
endmodule
